/* rtl/abt_pkg.sv */
package abt_pkg;

    // ------------------------------------------------------------
    // message layout and limits
    // ------------------------------------------------------------
    localparam logic [7:0] ABT_MAX_INF     = 8'h20;
    localparam logic [8:0] ABT_RSP_DEPTH   = 9'h100;
    localparam logic [8:0] ABT_HDR_LEN     = 9'h004;
    localparam int         ABT_NAD_IDX_POS = 0;
    localparam logic [4:0] ABT_LSI_MAX     = 5'h1F;
    localparam logic [4:0] ABT_LSI_RST     = 5'h00;

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    localparam logic [7:0] ABT_SW1_OK      = 8'h90;
    localparam logic [7:0] ABT_SW2_OK      = 8'h00;
    localparam logic [7:0] ABT_SW1_WARN_A  = 8'h62;
    localparam logic [7:0] ABT_SW1_WARN_B  = 8'h63;
    localparam logic [3:0] ABT_SW1_APP_HI  = 4'h9;
    localparam logic [7:0] ABT_SW1_PROACT  = 8'h91;
    localparam logic [7:0] ABT_SW1_TK_BUSY = 8'h93;
    localparam logic [7:0] ABT_SW2_TK_BUSY = 8'h00;

    // ------------------------------------------------------------
    // exchange cases and management operations
    // ------------------------------------------------------------
    localparam logic [1:0] ABT_CASE_1 = 2'h0;
    localparam logic [1:0] ABT_CASE_2 = 2'h1;
    localparam logic [1:0] ABT_CASE_3 = 2'h2;
    localparam logic [1:0] ABT_CASE_4 = 2'h3;

    localparam logic [1:0] ABT_MG_SELECT = 2'h0;
    localparam logic [1:0] ABT_MG_RESET  = 2'h1;
    localparam logic [1:0] ABT_MG_CONFIG = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       last;
        logic       chain;
        logic [7:0] node_address_byte;
        logic [7:0] data;
    } abt_rx_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       abort;
        logic [7:0] data;
    } abt_cmd_t;

    typedef struct packed {
        logic       valid;
        logic       done;
        logic [7:0] data;
        logic [7:0] sw1;
        logic [7:0] sw2;
    } abt_rsp_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       chain;
        logic [7:0] node_address_byte;
        logic [7:0] data;
    } abt_tx_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] op;
        logic [4:0] idx;
        logic       nad_ok;
    } abt_mgmt_t;

    typedef struct packed {
        logic valid;
        logic ok;
    } abt_ack_t;

    // data may travel only with warning, application or success status
    function automatic logic abt_data_allowed(input logic [7:0] sw1);
        return (sw1 == ABT_SW1_WARN_A) || (sw1 == ABT_SW1_WARN_B) ||
               (sw1[7:4] == ABT_SW1_APP_HI);
    endfunction : abt_data_allowed

endpackage : abt_pkg

/* rtl/abt_rsp_mem.sv */
`timescale 1ns/1ps
module abt_rsp_mem
    import abt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       ce_i,
    input  wire logic       we_i,
    input  wire logic [7:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] raddr_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem_r [0:255];

    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule : abt_rsp_mem

/* rtl/abt_transport.sv */
`timescale 1ns/1ps
module abt_transport
    import abt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       lsi_support_i,
    input  wire logic [4:0] lsi_top_i,
    input  wire logic       preagreed_i,
    input  wire logic       pps_done_i,
    input  wire logic       pps_lsi_i,
    input  wire abt_rx_t    rx_i,
    output abt_cmd_t        cmd_o,
    input  wire abt_rsp_t   rsp_i,
    input  wire logic       proactive_pend_i,
    input  wire logic [7:0] proactive_len_i,
    input  wire logic       env_busy_i,
    input  wire abt_mgmt_t  mgmt_i,
    output abt_ack_t        mgmt_ack_o,
    input  wire logic       tx_ready_i,
    output abt_tx_t         tx_o,
    output logic      [1:0] case_o,
    output logic            busy_o,
    output logic            nad_err_o,
    output logic            lsi_ind_o,
    output logic            lsi_used_o,
    output logic      [4:0] lsi_sel_o,
    output logic            lse_reset_o,
    output logic      [4:0] lse_reset_idx_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RXCMD = 6'b000010,
        ST_WAIT  = 6'b000100,
        ST_LOAD  = 6'b001000,
        ST_SHOW  = 6'b010000,
        ST_SEND  = 6'b100000
    } abt_state_t;

    abt_state_t state_r;
    abt_state_t state_nxt;
    logic       cap_done_r;
    logic       cfg_done_r;
    logic       nad_ok_r;
    logic [4:0] top_r;
    logic [8:0] cmd_len_r;
    logic [8:0] rsp_len_r;
    logic [8:0] idx_r;
    logic [7:0] blk_r;
    logic [7:0] sw1_r;
    logic [7:0] sw2_r;
    logic [7:0] mem_q;

    // ------------------------------------------------------------
    // receive, response, transmit and management qualification
    // ------------------------------------------------------------
    logic       nad_mode;
    logic [4:0] nad_idx;
    logic       nad_bad;
    logic       rx_take;
    logic       rx_end;
    logic       rsp_wr;
    logic       rsp_fin;
    logic       tx_take;
    logic       tx_final;
    logic       tx_blk_end;
    logic       mg_ok;
    always_comb begin
        nad_mode = lsi_used_o && cfg_done_r && nad_ok_r;
        nad_idx  = rx_i.node_address_byte[ABT_NAD_IDX_POS +: 5];
        nad_bad  = nad_mode && ((state_r == ST_IDLE) ? (nad_idx > top_r)
                                : (nad_idx != lsi_sel_o));
        rx_take  = rx_i.valid && !nad_bad &&
                   ((state_r == ST_IDLE) || (state_r == ST_RXCMD));
        rx_end   = rx_take && rx_i.last && !rx_i.chain;
        rsp_wr   = (state_r == ST_WAIT) && rsp_i.valid &&
                   (rsp_len_r < ABT_RSP_DEPTH);
        rsp_fin  = (state_r == ST_WAIT) && rsp_i.done;
        tx_take  = (state_r == ST_SEND) && tx_o.valid && tx_ready_i;
        tx_final = (idx_r == 9'(rsp_len_r + 9'h001));
        tx_blk_end = tx_final || (blk_r == 8'(ABT_MAX_INF - 8'h01));
        mg_ok    = mgmt_i.valid && lsi_used_o &&
                   ((mgmt_i.op == ABT_MG_CONFIG) || cfg_done_r ||
                    preagreed_i);
    end

    // ------------------------------------------------------------
    // exchange sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (rx_end) begin
                    state_nxt = env_busy_i ? ST_LOAD : ST_WAIT;
                end else if (rx_take) begin
                    state_nxt = ST_RXCMD;
                end
            end
            ST_RXCMD: state_nxt = !rx_end ? ST_RXCMD
                                : env_busy_i ? ST_LOAD : ST_WAIT;
            ST_WAIT:  state_nxt = rsp_fin ? ST_LOAD : ST_WAIT;
            ST_LOAD:  state_nxt = ST_SHOW;
            ST_SHOW:  state_nxt = ST_SEND;
            ST_SEND:  state_nxt = !tx_take ? ST_SEND
                                : tx_final ? ST_IDLE : ST_LOAD;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            busy_o <= (state_nxt != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // command path to application
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_o     <= '0;
            cmd_len_r <= 9'h000;
        end else if (ce_i) begin
            cmd_o.valid <= rx_take;
            cmd_o.data  <= rx_i.data;
            cmd_o.last  <= rx_end && !env_busy_i;
            cmd_o.abort <= rx_end && env_busy_i;
            if (rx_take) begin
                if (state_r == ST_IDLE) begin
                    cmd_len_r <= 9'h001;
                end else if (cmd_len_r != 9'h1FF) begin
                    cmd_len_r <= 9'(cmd_len_r + 9'h001);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // response capture and status handling
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_len_r <= 9'h000;
            sw1_r     <= ABT_SW1_OK;
            sw2_r     <= ABT_SW2_OK;
        end else if (ce_i) begin
            if (rx_end) begin
                rsp_len_r <= 9'h000;
                if (env_busy_i) begin
                    sw1_r <= ABT_SW1_TK_BUSY;
                    sw2_r <= ABT_SW2_TK_BUSY;
                end
            end else if (rsp_fin) begin
                if (!abt_data_allowed(rsp_i.sw1)) begin
                    rsp_len_r <= 9'h000;
                end
                if ((rsp_i.sw1 == ABT_SW1_OK) && (rsp_i.sw2 == ABT_SW2_OK)
                    && proactive_pend_i) begin
                    sw1_r <= ABT_SW1_PROACT;
                    sw2_r <= proactive_len_i;
                end else begin
                    sw1_r <= rsp_i.sw1;
                    sw2_r <= rsp_i.sw2;
                end
            end else if (rsp_wr) begin
                rsp_len_r <= 9'(rsp_len_r + 9'h001);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            case_o <= ABT_CASE_1;
        end else if (ce_i && (state_r == ST_LOAD) && (idx_r == 9'h000)) begin
            case ({cmd_len_r > 9'(ABT_HDR_LEN + 9'h001),
                   rsp_len_r != 9'h000})
                2'b00:   case_o <= ABT_CASE_1;
                2'b01:   case_o <= ABT_CASE_2;
                2'b10:   case_o <= ABT_CASE_3;
                default: case_o <= ABT_CASE_4;
            endcase
        end
    end

    abt_rsp_mem u_mem (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (rsp_wr),
        .waddr_i (rsp_len_r[7:0]),
        .wdata_i (rsp_i.data),
        .raddr_i (idx_r[7:0]),
        .rdata_o (mem_q)
    );

    // ------------------------------------------------------------
    // response transmit in chained blocks
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_r <= 9'h000;
            blk_r <= 8'h00;
        end else if (ce_i) begin
            if (rx_end || rsp_fin) begin
                idx_r <= 9'h000;
                blk_r <= 8'h00;
            end else if (tx_take) begin
                idx_r <= 9'(idx_r + 9'h001);
                blk_r <= tx_blk_end ? 8'h00 : 8'(blk_r + 8'h01);
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_o <= '0;
        end else if (ce_i) begin
            if (state_r == ST_SHOW) begin
                tx_o.valid <= 1'b1;
                tx_o.last  <= tx_blk_end;
                tx_o.chain <= tx_blk_end && !tx_final;
                tx_o.node_address_byte   <= nad_mode ? {3'h0, lsi_sel_o} : 8'h00;
                if (idx_r < rsp_len_r) begin
                    tx_o.data <= mem_q;
                end else if (idx_r == rsp_len_r) begin
                    tx_o.data <= sw1_r;
                end else begin
                    tx_o.data <= sw2_r;
                end
            end else if (tx_take) begin
                tx_o.valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // logical interface management
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_done_r <= 1'b0;
            lsi_ind_o  <= 1'b0;
            top_r      <= ABT_LSI_RST;
        end else if (ce_i && !cap_done_r) begin
            cap_done_r <= 1'b1;
            lsi_ind_o  <= lsi_support_i;
            top_r      <= (lsi_top_i > ABT_LSI_MAX) ? ABT_LSI_MAX
                                                    : lsi_top_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lsi_used_o      <= 1'b0;
            lsi_sel_o       <= ABT_LSI_RST;
            cfg_done_r      <= 1'b0;
            nad_ok_r        <= 1'b0;
            lse_reset_o     <= 1'b0;
            lse_reset_idx_o <= ABT_LSI_RST;
            mgmt_ack_o      <= '0;
            nad_err_o       <= 1'b0;
        end else if (ce_i) begin
            lse_reset_o      <= 1'b0;
            mgmt_ack_o.valid <= mgmt_i.valid;
            mgmt_ack_o.ok    <= 1'b0;
            nad_err_o        <= rx_i.valid && nad_bad;
            if (pps_done_i) begin
                lsi_used_o <= lsi_ind_o && pps_lsi_i;
                lsi_sel_o  <= ABT_LSI_RST;
                cfg_done_r <= 1'b0;
                nad_ok_r   <= 1'b0;
            end else if (rx_take && (state_r == ST_IDLE) && nad_mode) begin
                lsi_sel_o <= nad_idx;
            end else if (mg_ok) begin
                case (mgmt_i.op)
                    ABT_MG_SELECT: begin
                        if (mgmt_i.idx <= top_r) begin
                            lsi_sel_o     <= mgmt_i.idx;
                            mgmt_ack_o.ok <= 1'b1;
                        end
                    end
                    ABT_MG_RESET: begin
                        if (mgmt_i.idx <= top_r) begin
                            lse_reset_o     <= 1'b1;
                            lse_reset_idx_o <= mgmt_i.idx;
                            mgmt_ack_o.ok   <= 1'b1;
                        end
                    end
                    ABT_MG_CONFIG: begin
                        cfg_done_r    <= 1'b1;
                        nad_ok_r      <= mgmt_i.nad_ok;
                        mgmt_ack_o.ok <= 1'b1;
                    end
                    default: mgmt_ack_o.ok <= 1'b0;
                endcase
            end
        end
    end

endmodule : abt_transport

/* tb/abt_term_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// terminal side sink for response bytes
// ------------------------------------------------------------
module abt_term_model
    import abt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    output logic      ready_o
);
    logic [1:0] phase_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
        end
    end

    // takes bytes as sent, stalls two cycles in three when slow
    assign ready_o = !slow_i || (phase_r == 2'h2);
endmodule : abt_term_model

/* tb/abt_transport_chk.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the transport block
// ------------------------------------------------------------
module abt_transport_chk
    import abt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       lsi_support_i,
    input  wire logic [4:0] lsi_top_i,
    input  wire logic       pps_done_i,
    input  wire logic       pps_lsi_i,
    input  wire abt_rx_t    rx_i,
    input  wire abt_cmd_t   cmd_o,
    input  wire abt_rsp_t   rsp_i,
    input  wire logic       env_busy_i,
    input  wire abt_mgmt_t  mgmt_i,
    input  wire abt_ack_t   mgmt_ack_o,
    input  wire logic       tx_ready_i,
    input  wire abt_tx_t    tx_o,
    input  wire logic       busy_o,
    input  wire logic       nad_err_o,
    input  wire logic       lsi_ind_o,
    input  wire logic       lsi_used_o,
    input  wire logic [4:0] lsi_sel_o,
    input  wire logic       lse_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_status;
        rsp_i.done && busy_o && !tx_o.valid && ce_i;
    endsequence
    sequence s_send;
        !tx_o.valid ##1 !tx_o.valid ##1 tx_o.valid;
    endsequence

    a_first_send: assert property (s_status |=> s_send)
        else $error("response start not three cycles after status");
    a_cmd_copy: assert property (cmd_o.valid |->
        $past(rx_i.valid) && cmd_o.data == $past(rx_i.data))
        else $error("command byte not copied");
    a_ind_strap: assert property (
        !$past(rst_i) && $past(rst_i, 2) |-> lsi_ind_o == lsi_support_i)
        else $error("support indication wrong");
    a_pps_zero: assert property (
        pps_done_i && pps_lsi_i && lsi_ind_o && ce_i
        |=> lsi_used_o && lsi_sel_o == ABT_LSI_RST)
        else $error("index zero not selected after exchange");
    a_ack_pulse: assert property (
        mgmt_i.valid && ce_i |=> mgmt_ack_o.valid)
        else $error("manage request not acknowledged");
    a_ack_gate: assert property (mgmt_ack_o.ok |->
        $past(lsi_used_o) && ($past(mgmt_i.op) == ABT_MG_CONFIG ||
        $past(mgmt_i.idx) <= $past(lsi_top_i)))
        else $error("manage request accepted out of range");
    a_reset_elem: assert property (
        mgmt_ack_o.ok && $past(mgmt_i.op) == ABT_MG_RESET
        |-> ##[0:1] lse_reset_o)
        else $error("element reset not pulsed");
    a_tx_hold: assert property (
        tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o))
        else $error("response byte changed while stalled");
    a_chain_last: assert property (
        tx_o.valid && tx_o.chain |-> tx_o.last)
        else $error("chain flag off block end");
    a_nad_drop: assert property (
        nad_err_o |-> !cmd_o.valid && $past(rx_i.valid))
        else $error("foreign byte passed on");
    a_busy_abort: assert property (cmd_o.abort |->
        $past(env_busy_i) && $past(rx_i.last) && !cmd_o.last)
        else $error("abort without busy toolkit");
endmodule : abt_transport_chk

bind abt_transport abt_transport_chk u_abt_transport_chk (
    .clk_i, .rst_i, .ce_i, .lsi_support_i, .lsi_top_i, .pps_done_i,
    .pps_lsi_i, .rx_i, .cmd_o, .rsp_i, .env_busy_i, .mgmt_i, .mgmt_ack_o,
    .tx_ready_i, .tx_o, .busy_o, .nad_err_o, .lsi_ind_o, .lsi_used_o,
    .lsi_sel_o, .lse_reset_o
);

/* tb/abt_transport_tb_top.sv */
`timescale 1ns/1ps
module abt_transport_tb_top
    import abt_pkg::*;
;
    logic       clk_i            = 1'b0;
    logic       rst_i            = 1'b1;
    logic       pps_done_i       = 1'b0;
    logic       pps_lsi_i        = 1'b0;
    logic       proactive_pend_i = 1'b0;
    logic [7:0] proactive_len_i  = 8'h17;
    logic       env_busy_i       = 1'b0;
    logic       preagreed_i      = 1'b0;
    logic       slow_i           = 1'b0;
    logic       nad_mode         = 1'b0;
    abt_rx_t    rx_i             = '0;
    abt_rsp_t   rsp_i            = '0;
    abt_mgmt_t  mgmt_i           = '0;
    int         num_errors       = 0;
    int         compares         = 0;
    int         cycles           = 0;
    logic       tx_ready_i, last_abort;
    logic [1:0] seen_case, case_o;
    abt_cmd_t   cmd_o;
    abt_ack_t   mgmt_ack_o;
    abt_tx_t    tx_o;
    logic       busy_o, nad_err_o, lsi_ind_o, lsi_used_o, lse_reset_o;
    logic [4:0] lsi_sel_o, lse_reset_idx_o;
    logic [7:0] cmd_q[$];
    abt_tx_t    tx_q[$];

    abt_transport u_abt_transport (
        .clk_i, .rst_i, .ce_i(1'b1), .lsi_support_i(1'b1),
        .lsi_top_i(5'h03), .preagreed_i, .pps_done_i, .pps_lsi_i,
        .rx_i, .cmd_o, .rsp_i, .proactive_pend_i, .proactive_len_i,
        .env_busy_i, .mgmt_i, .mgmt_ack_o, .tx_ready_i, .tx_o, .case_o,
        .busy_o, .nad_err_o, .lsi_ind_o, .lsi_used_o, .lsi_sel_o,
        .lse_reset_o, .lse_reset_idx_o
    );
    abt_term_model u_abt_term_model (
        .clk_i, .rst_i, .slow_i, .ready_o(tx_ready_i)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cmd_o.valid) begin
            cmd_q.push_back(cmd_o.data);
            last_abort = cmd_o.abort;
        end
        if (tx_o.valid && tx_ready_i) begin
            if (tx_q.size() == 0) seen_case = case_o;
            tx_q.push_back(tx_o);
        end
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic put_byte(input logic last, input logic chain,
                            input logic [7:0] node_address_byte, input logic [7:0] d);
        @(negedge clk_i);
        rx_i <= '{1'b1, last, chain, node_address_byte, d};
    endtask : put_byte

    task automatic wait_idle();
        for (int t = 0; t < 2000 && busy_o !== 1'b0; t++) @(negedge clk_i);
    endtask : wait_idle

    task automatic mgmt(input logic [1:0] op, input logic [4:0] idx,
                        input logic ok);
        @(negedge clk_i);
        mgmt_i <= '{1'b1, op, idx, 1'b1};
        @(negedge clk_i);
        mgmt_i <= '0;
        chk("ack", {mgmt_ack_o.valid, mgmt_ack_o.ok}, {1'b1, ok});
    endtask : mgmt

    task automatic run(input int len, input int n, input logic [7:0] sw1,
                       input logic [7:0] sw2, input logic pend,
                       input logic ebusy, input logic [7:0] node_address_byte);
        int         nd;
        int         tot;
        logic       pro;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] exp_b;
        pro = pend && sw1 == ABT_SW1_OK && sw2 == ABT_SW2_OK;
        s1 = ebusy ? ABT_SW1_TK_BUSY : pro ? ABT_SW1_PROACT : sw1;
        s2 = ebusy ? ABT_SW2_TK_BUSY : pro ? proactive_len_i : sw2;
        nd = (!ebusy && (sw1 == 8'h62 || sw1 == 8'h63 || sw1[7:4] == 4'h9))
             ? n : 0;
        tot = nd + 2;
        tx_q = {};
        cmd_q = {};
        proactive_pend_i <= pend;
        for (int i = 0; i < len; i++) begin
            put_byte(i % 32 == 31 || i == len - 1,
                     i % 32 == 31 && i != len - 1, node_address_byte, 8'(i + 8'h40));
            env_busy_i <= ebusy && i == len - 1;
        end
        @(negedge clk_i);
        rx_i <= '0;
        env_busy_i <= 1'b0;
        if (!ebusy) begin
            for (int i = 0; i <= n; i++) begin
                @(negedge clk_i);
                rsp_i <= '{i < n, i == n, 8'(i + 8'hA0), sw1, sw2};
            end
            @(negedge clk_i);
            rsp_i <= '0;
        end
        wait_idle();
        chk("cmd count", 16'(cmd_q.size()), 16'(len));
        for (int i = 0; i < len && i < cmd_q.size(); i++)
            chk("cmd byte", cmd_q[i], 8'(i + 8'h40));
        chk("abort", last_abort, ebusy);
        chk("tx count", 16'(tx_q.size()), 16'(tot));
        for (int i = 0; i < tot && i < tx_q.size(); i++) begin
            exp_b = i < nd ? 8'(i + 8'hA0) : (i == nd ? s1 : s2);
            chk("tx byte", tx_q[i].data, exp_b);
            chk("tx end", {tx_q[i].last, tx_q[i].chain},
                {i % 32 == 31 || i == tot - 1,
                 i % 32 == 31 && i != tot - 1});
            chk("tx nad", tx_q[i].node_address_byte, nad_mode ? node_address_byte : 8'h00);
        end
        chk("case", seen_case, {len > 5, nd > 0});
    endtask : run

    initial begin
        repeat (6) @(negedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk("ind", lsi_ind_o, 1'b1);
        pps_done_i <= 1'b1;
        pps_lsi_i <= 1'b1;
        @(negedge clk_i);
        pps_done_i <= 1'b0;
        @(negedge clk_i);
        chk("used sel", {lsi_used_o, lsi_sel_o}, 6'h20);
        run(4, 0, 8'h90, 8'h00, 1'b0, 1'b0, 8'h01);
        chk("sel", lsi_sel_o, 5'h00);
        slow_i <= 1'b1;
        run(5, 40, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        run(40, 0, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        slow_i <= 1'b0;
        run(8, 3, 8'h62, 8'h81, 1'b0, 1'b0, 8'h00);
        run(8, 3, 8'h63, 8'hC1, 1'b0, 1'b0, 8'h00);
        run(8, 3, 8'h6F, 8'h82, 1'b0, 1'b0, 8'h00);
        run(8, 3, 8'h9F, 8'h10, 1'b0, 1'b0, 8'h00);
        run(8, 2, 8'h90, 8'h00, 1'b1, 1'b0, 8'h00);
        run(5, 3, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        run(6, 0, 8'h90, 8'h00, 1'b0, 1'b1, 8'h00);
        mgmt(ABT_MG_SELECT, 5'h02, 1'b0);
        preagreed_i <= 1'b1;
        mgmt(ABT_MG_SELECT, 5'h01, 1'b1);
        chk("sel", lsi_sel_o, 5'h01);
        preagreed_i <= 1'b0;
        mgmt(ABT_MG_CONFIG, 5'h00, 1'b1);
        mgmt(ABT_MG_SELECT, 5'h04, 1'b0);
        mgmt(ABT_MG_SELECT, 5'h02, 1'b1);
        chk("sel", lsi_sel_o, 5'h02);
        mgmt(ABT_MG_RESET, 5'h01, 1'b1);
        chk("reset idx", lse_reset_idx_o, 5'h01);
        nad_mode = 1'b1;
        run(4, 0, 8'h90, 8'h00, 1'b0, 1'b0, 8'h01);
        chk("sel", lsi_sel_o, 5'h01);
        cmd_q = {};
        put_byte(1'b0, 1'b0, 8'h03, 8'h40);
        put_byte(1'b0, 1'b0, 8'h02, 8'h41);
        @(negedge clk_i);
        chk("nad err", nad_err_o, 1'b1);
        rx_i <= '{1'b1, 1'b1, 1'b0, 8'h03, 8'h42};
        @(negedge clk_i);
        rx_i <= '0;
        @(negedge clk_i);
        chk("sel", lsi_sel_o, 5'h03);
        rsp_i <= '{1'b0, 1'b1, 8'h00, 8'h90, 8'h00};
        @(negedge clk_i);
        rsp_i <= '0;
        wait_idle();
        chk("cmd count", 16'(cmd_q.size()), 16'h0002);
        stop_test();
    end
endmodule : abt_transport_tb_top
